// ==== include/sar_pkg.sv ====
package sar_pkg;

   // ****************************************************
   // Register map
   // ****************************************************
   // Register indices; the byte address is four times the index.
   localparam logic [7:0] IDX_TIMING = 8'h26;
   localparam logic [7:0] IDX_PINSEL = 8'h27;
   localparam logic [7:0] IDX_CHAN1  = 8'h28;
   localparam logic [7:0] IDX_CTRL   = 8'h30;
   localparam logic [7:0] IDX_STATUS = 8'h31;
   localparam int         ADDR_W     = 10;
   localparam int         NCH        = 8;

   // ****************************************************
   // Field positions
   // ****************************************************
   localparam int TIM_EDGE  = 7;
   localparam int TIM_FRAME_SYNC = 6;
   localparam int TIM_BCLK  = 5;
   localparam int TIM_DLY_H = 4;
   localparam int CH_EN     = 5;
   localparam int CH_SLOT_H = 4;
   localparam int CTL_MODE  = 0;
   localparam int CTL_POL   = 1;
   localparam int CTL_FMT_L = 2;
   localparam int CTL_WL_L  = 4;

   // ****************************************************
   // Values after reset
   // ****************************************************
   localparam logic [7:0]  RST_TIMING = 8'h00;
   localparam logic [7:0]  RST_PINSEL = 8'h00;
   localparam logic [7:0]  RST_CTRL   = 8'h00;
   localparam logic [4:0]  RST_SLOT0  = 5'h00;
   localparam logic [15:0] RST_COUNT  = 16'h0000;

   // ****************************************************
   // Frame formats and counts
   // ****************************************************
   localparam logic [1:0] FMT_TDM   = 2'h0;
   localparam logic [1:0] FMT_I2S   = 2'h1;
   localparam logic [1:0] FMT_LJ    = 2'h2;
   localparam logic [5:0] WL_BITS [4] = '{6'h10, 6'h14, 6'h18, 6'h20};
   localparam logic [5:0] I2S_OFF   = 6'h01;
   localparam logic [4:0] LAST_TDM  = 5'h1F;
   localparam logic [4:0] LAST_HALF = 5'h0F;
   localparam int         SYNC_W    = 66;

endpackage

// ==== rtl/sar_sync.sv ====
module sar_sync #(
   parameter int W = 1
) (
   // Destination clock and reset.
   input  wire logic         clk,
   input  wire logic         rst_n,
   // Level in and synchronised level out.
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);

   logic [W-1:0] meta;

   // Two flops in a row; nothing but the second flop reads the first.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta <= '0;
         dout <= '0;
      end else begin
         meta <= din;
         dout <= meta;
      end
   end

endmodule // sar_sync

// ==== rtl/sar_clksel.sv ====
module sar_clksel (
   // Candidate bit clocks and reset.
   input  wire logic clk_ext,
   input  wire logic clk_int,
   input  wire logic arst_n,
   // Selection from the register side.
   input  wire logic sel_int,
   input  wire logic invert,
   // Capture clock.
   output logic      clk_out
);

   logic [1:0] ext_en;
   logic [1:0] int_en;

   // Each side enables only once the other has stopped, so no runt
   // pulse reaches the capture logic. A stopped source cannot hand over.
   always_ff @(negedge clk_ext or negedge arst_n) begin
      if (!arst_n) begin
         ext_en <= 2'b00;
      end else begin
         ext_en <= {ext_en[0], ~sel_int & ~int_en[1]};
      end
   end

   // Enable chain of the internal clock.
   always_ff @(negedge clk_int or negedge arst_n) begin
      if (!arst_n) begin
         int_en <= 2'b00;
      end else begin
         int_en <= {int_en[0], sel_int & ~ext_en[1]};
      end
   end

   // Inversion moves the capture to the opposite edge of the bit clock.
   assign clk_out = ((clk_ext & ext_en[1]) | (clk_int & int_en[1])) ^ invert;

endmodule // sar_clksel

// ==== rtl/sar_rx.sv ====
// Functional notes
// - capture edge bit moves sampling half cycle
// - controller mode picks internal or external frame sync
// - controller mode picks internal or external bit clock
// - delay field postpones slot 0 MSB 0..31
// - zero delay means standard MSB position
// - delay applies to both halves in I2S/LJ
// - per channel select bit picks input pin
// - both configuration registers reset to zero
// - slot numbers 16..31 mean right half in I2S/LJ
// - channel enable gates delivery of slot data
module sar_rx
   import sar_pkg::*;
(
   // System clock and reset.
   input  wire logic                 clock,
   input  wire logic                 arst_n,
   // APB slave.
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [ADDR_W-1:0]    paddr,
   input  wire logic [31:0]          pwdata,
   input  wire logic [3:0]           pstrb,
   output logic      [31:0]          prdata,
   output logic                      pready,
   output logic                      pslverr,
   // Serial link pins.
   input  wire logic                 bitclk_ext,
   input  wire logic                 bitclk_int,
   input  wire logic                 frame_sync_ext,
   input  wire logic                 frame_sync_int,
   input  wire logic                 serial_in_first,
   input  wire logic                 serial_in_second,
   // Delivered samples, MSB aligned.
   output logic      [NCH-1:0][31:0] chan_data,
   output logic      [NCH-1:0]       chan_valid
);

   // ****************************************************
   // Declarations
   // ****************************************************
   typedef enum logic [1:0] {ST_HUNT, ST_WAIT, ST_SHIFT} sar_lstate_t;

   logic [7:0]           rx_capture_timing;
   logic [7:0]           rx_channel_pin_select;
   logic [7:0]           ctrl;
   logic [5:0]           chan_cfg [NCH];
   logic [15:0]          sample_cnt;
   logic [7:0]           idx;
   logic                 wr_en;
   logic [31:0]          rdata;
   logic                 sel_bclk;
   logic                 sel_fs;
   logic                 cap_inv;
   logic                 lclk;
   logic [1:0]           lrst_q;
   logic                 lrst_n;
   logic [NCH-1:0]       en_s;
   logic [NCH-1:0][4:0]  slot_s;
   logic [SYNC_W-1:0]    cfg_sys;
   logic [SYNC_W-1:0]    cfg_l;
   logic                 fs_sel_l;
   logic [4:0]           dly_l;
   logic [NCH-1:0]       pin_l;
   logic [NCH-1:0]       en_l;
   logic [NCH-1:0][4:0]  slot_l;
   logic [1:0]           fmt_l;
   logic [1:0]           wlc_l;
   logic                 fs_q;
   logic                 fs_qq;
   logic                 d1_q;
   logic                 d2_q;
   logic                 rise;
   logic                 fall;
   logic                 two_half;
   logic                 hstart;
   logic                 right_now;
   logic [5:0]           target;
   logic [5:0]           wl;
   logic [5:0]           wl_m1;
   logic [4:0]           last_slot;
   sar_lstate_t          st;
   logic [5:0]           waitc;
   logic [5:0]           bitc;
   logic [4:0]           slot;
   logic                 half;
   logic                 shift_en;
   logic                 last;
   logic [31:0]          sr1;
   logic [31:0]          sr2;
   logic [31:0]          w1;
   logic [31:0]          w2;
   logic [4:0]           cur_slot;
   logic [31:0]          hold [NCH];
   logic [NCH-1:0]       tog;
   logic [NCH-1:0]       tog_s;
   logic [NCH-1:0]       tog_q;

   // Register window check, shared by read answer and write gating.
   function automatic logic reg_hit(input logic [ADDR_W-1:0] a);
      logic [7:0] i;
      i = a[ADDR_W-1:2];
      reg_hit = (a[1:0] == 2'h0) && (i >= IDX_TIMING) && (i <= IDX_STATUS);
   endfunction

   // Moves the last n received bits to the top of the word.
   function automatic logic [31:0] msb_align(input logic [31:0] w,
                                            input logic [5:0]  n);
      msb_align = w << (6'h20 - n);
   endfunction

   // ****************************************************
   // APB register file
   // ****************************************************
   assign idx    = paddr[ADDR_W-1:2];
   assign pready = 1'b1;
   assign wr_en  = psel & penable & pwrite & pstrb[0] & reg_hit(paddr);

   // Timing, pin routing and mode registers.
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         rx_capture_timing     <= RST_TIMING;
         rx_channel_pin_select <= RST_PINSEL;
         ctrl                  <= RST_CTRL;
      end else if (wr_en) begin
         if (idx == IDX_TIMING) begin
            rx_capture_timing <= pwdata[7:0];
         end
         if (idx == IDX_PINSEL) begin
            rx_channel_pin_select <= pwdata[7:0];
         end
         if (idx == IDX_CTRL) begin
            ctrl <= {2'b00, pwdata[5:0]};
         end
      end
   end

   // Per-channel enable and slot registers; slot defaults to the index.
   for (genvar gi = 0; gi < NCH; gi++) begin : g_cfg
      always_ff @(posedge clock or negedge arst_n) begin
         if (!arst_n) begin
            chan_cfg[gi] <= {1'b0, RST_SLOT0 + 5'(gi)};
         end else if (wr_en && idx == IDX_CHAN1 + 8'(gi)) begin
            chan_cfg[gi] <= pwdata[5:0];
         end
      end
      assign en_s[gi]   = chan_cfg[gi][CH_EN];
      assign slot_s[gi] = chan_cfg[gi][CH_SLOT_H:0];
   end

   // Read value of the addressed register; reserved bits read zero.
   always_comb begin
      rdata = 32'h0000_0000;
      case (idx)
         IDX_TIMING: rdata = {24'h00_0000, rx_capture_timing};
         IDX_PINSEL: rdata = {24'h00_0000, rx_channel_pin_select};
         IDX_CTRL:   rdata = {24'h00_0000, ctrl};
         IDX_STATUS: rdata = {16'h0000, sample_cnt};
         default: begin
            if (idx >= IDX_CHAN1 && idx < IDX_CTRL) begin
               rdata = {26'h000_0000, chan_cfg[3'(idx - IDX_CHAN1)]};
            end
         end
      endcase
   end

   // Answer is captured in the setup cycle so that it comes from flops.
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (psel && !penable) begin
         prdata  <= pwrite ? 32'h0000_0000 : rdata;
         pslverr <= ~reg_hit(paddr);
      end
   end

   // ****************************************************
   // Capture clock selection
   // ****************************************************
   // Internal sources only count in controller mode.
   assign sel_bclk = ctrl[CTL_MODE] & rx_capture_timing[TIM_BCLK];
   assign sel_fs   = ctrl[CTL_MODE] & rx_capture_timing[TIM_FRAME_SYNC];
   // Inverting the clock samples on the following, opposite edge.
   assign cap_inv  = ctrl[CTL_POL] ^ rx_capture_timing[TIM_EDGE];

   sar_clksel u_clksel (
      .clk_ext (bitclk_ext),
      .clk_int (bitclk_int),
      .arst_n  (arst_n),
      .sel_int (sel_bclk),
      .invert  (cap_inv),
      .clk_out (lclk)
   );

   // Link reset asserts at once and releases on the capture clock.
   always_ff @(posedge lclk or negedge arst_n) begin
      if (!arst_n) begin
         lrst_q <= 2'b00;
      end else begin
         lrst_q <= {lrst_q[0], 1'b1};
      end
   end
   assign lrst_n = lrst_q[1];

   // Configuration is quasi-static, so a two-flop level crossing is
   // enough; change it only while no frame is being received.
   assign cfg_sys = {sel_fs, rx_capture_timing[TIM_DLY_H:0],
                     rx_channel_pin_select, en_s, slot_s,
                     ctrl[CTL_FMT_L+:2], ctrl[CTL_WL_L+:2]};

   sar_sync #(.W(SYNC_W)) u_cfg_sync (
      .clk   (lclk),
      .rst_n (lrst_n),
      .din   (cfg_sys),
      .dout  (cfg_l)
   );
   assign {fs_sel_l, dly_l, pin_l, en_l, slot_l, fmt_l, wlc_l} = cfg_l;

   // ****************************************************
   // Link side framing
   // ****************************************************
   // Pins are launched on the bit clock, so they need no synchroniser.
   always_ff @(posedge lclk or negedge lrst_n) begin
      if (!lrst_n) begin
         fs_q  <= 1'b0;
         fs_qq <= 1'b0;
         d1_q  <= 1'b0;
         d2_q  <= 1'b0;
      end else begin
         fs_q  <= fs_sel_l ? frame_sync_int : frame_sync_ext;
         fs_qq <= fs_q;
         d1_q  <= serial_in_first;
         d2_q  <= serial_in_second;
      end
   end

   assign rise      = fs_q & ~fs_qq;
   assign fall      = ~fs_q & fs_qq;
   assign two_half  = (fmt_l != FMT_TDM);
   // Left and right halves each restart the count from slot 0.
   assign hstart    = rise | (two_half & fall);
   assign right_now = (fmt_l == FMT_I2S) ? rise : ((fmt_l == FMT_LJ) & fall);
   // Standard MSB place plus the programmed extra bit clocks.
   assign target    = {1'b0, dly_l} +
                      ((fmt_l == FMT_I2S) ? I2S_OFF : 6'h00);
   assign wl        = WL_BITS[wlc_l];
   assign wl_m1     = wl - 6'h01;
   assign last_slot = two_half ? LAST_HALF : LAST_TDM;

   // Framing state: wait out the offset, then count bits and slots.
   always_ff @(posedge lclk or negedge lrst_n) begin
      if (!lrst_n) begin
         st    <= ST_HUNT;
         waitc <= 6'h00;
         bitc  <= 6'h00;
         slot  <= 5'h00;
         half  <= 1'b0;
      end else if (hstart) begin
         half <= right_now;
         slot <= 5'h00;
         if (target == 6'h00) begin
            st   <= ST_SHIFT;
            bitc <= 6'h01;
         end else begin
            st    <= ST_WAIT;
            waitc <= target - 6'h01;
         end
      end else begin
         case (st)
            ST_WAIT: begin
               if (waitc == 6'h00) begin
                  st   <= ST_SHIFT;
                  bitc <= 6'h01;
               end else begin
                  waitc <= waitc - 6'h01;
               end
            end
            ST_SHIFT: begin
               if (bitc == wl_m1) begin
                  bitc <= 6'h00;
                  slot <= slot + 5'h01;
                  if (slot == last_slot) begin
                     st <= ST_HUNT;
                  end
               end else begin
                  bitc <= bitc + 6'h01;
               end
            end
            default: st <= ST_HUNT;
         endcase
      end
   end

   assign shift_en = hstart ? (target == 6'h00)
                            : (st == ST_SHIFT || (st == ST_WAIT && waitc == 6'h00));
   assign last     = !hstart && st == ST_SHIFT && bitc == wl_m1;

   // Both pins are shifted side by side; each channel picks one later.
   always_ff @(posedge lclk or negedge lrst_n) begin
      if (!lrst_n) begin
         sr1 <= 32'h0000_0000;
         sr2 <= 32'h0000_0000;
      end else if (shift_en) begin
         sr1 <= {sr1[30:0], d1_q};
         sr2 <= {sr2[30:0], d2_q};
      end
   end

   assign w1       = msb_align({sr1[30:0], d1_q}, wl);
   assign w2       = msb_align({sr2[30:0], d2_q}, wl);
   // Right-half slots are numbered from 16 upward.
   assign cur_slot = two_half ? {half, slot[3:0]} : slot;

   // ****************************************************
   // Channel capture and hand-over
   // ****************************************************
   // A toggle announces each new word; the word then stands for a slot.
   for (genvar gi = 0; gi < NCH; gi++) begin : g_ch
      always_ff @(posedge lclk or negedge lrst_n) begin
         if (!lrst_n) begin
            hold[gi] <= 32'h0000_0000;
            tog[gi]  <= 1'b0;
         end else if (last && en_l[gi] && slot_l[gi] == cur_slot) begin
            hold[gi] <= pin_l[gi] ? w2 : w1;
            tog[gi]  <= ~tog[gi];
         end
      end
   end

   sar_sync #(.W(NCH)) u_tog_sync (
      .clk   (clock),
      .rst_n (arst_n),
      .din   (tog),
      .dout  (tog_s)
   );

   // A toggle edge copies the settled word and pulses its valid.
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         tog_q      <= '0;
         chan_valid <= '0;
         chan_data  <= '0;
      end else begin
         tog_q      <= tog_s;
         chan_valid <= tog_s ^ tog_q;
         for (int i = 0; i < NCH; i++) begin
            if (tog_s[i] ^ tog_q[i]) begin
               chan_data[i] <= hold[i];
            end
         end
      end
   end

   // Delivered sample counter, readable as status.
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         sample_cnt <= RST_COUNT;
      end else begin
         sample_cnt <= sample_cnt + 16'($countones(chan_valid));
      end
   end

   // ****************************************************
   // Assertions
   // ****************************************************
   logic [5:0] since_q;
   logic [5:0] tgt_q;
   logic       first_bit;

   assign first_bit = shift_en && (hstart || st == ST_WAIT);

   // Bit clocks since the last half-frame start, for the delay check.
   always_ff @(posedge lclk or negedge lrst_n) begin
      if (!lrst_n) begin
         since_q <= 6'h00;
         tgt_q   <= 6'h00;
      end else if (hstart) begin
         since_q <= 6'h01;
         tgt_q   <= target;
      end else if (since_q != 6'h3F) begin
         since_q <= since_q + 6'h01;
      end
   end

   property p_rst_zero;
      @(posedge clock) disable iff (!arst_n)
      !$past(arst_n) |-> rx_capture_timing == 8'h00
                         && rx_channel_pin_select == 8'h00;
   endproperty
   a_rst_zero: assert property (p_rst_zero)
      else $error("config registers not zero after reset");

   property p_edge;
      @(posedge clock) disable iff (!arst_n)
      wr_en && idx == IDX_TIMING
      |=> cap_inv == ($past(pwdata[TIM_EDGE]) ^ ctrl[CTL_POL]);
   endproperty
   a_edge: assert property (p_edge)
      else $error("capture edge does not follow edge bit");

   property p_fs_sel;
      @(posedge clock) disable iff (!arst_n)
      wr_en && idx == IDX_TIMING && ctrl[CTL_MODE]
      |=> sel_fs == $past(pwdata[TIM_FRAME_SYNC]);
   endproperty
   a_fs_sel: assert property (p_fs_sel)
      else $error("frame sync select wrong");

   property p_bclk_sel;
      @(posedge clock) disable iff (!arst_n)
      !ctrl[CTL_MODE] |-> !sel_bclk;
   endproperty
   a_bclk_sel: assert property (p_bclk_sel)
      else $error("internal bit clock used outside controller mode");

   property p_delay;
      @(posedge lclk) disable iff (!lrst_n)
      first_bit && !hstart |-> since_q == tgt_q;
   endproperty
   a_delay: assert property (p_delay)
      else $error("first data bit not at programmed offset");

   property p_nodelay;
      @(posedge lclk) disable iff (!lrst_n)
      hstart && dly_l == 5'h00 && fmt_l != FMT_I2S |-> shift_en;
   endproperty
   a_nodelay: assert property (p_nodelay)
      else $error("zero delay did not take MSB at frame edge");

   property p_halves;
      @(posedge lclk) disable iff (!lrst_n)
      fall |-> hstart == (fmt_l != FMT_TDM);
   endproperty
   a_halves: assert property (p_halves)
      else $error("half-frame start wrong for format");

   property p_right_slot;
      @(posedge lclk) disable iff (!lrst_n)
      last && two_half && half |-> cur_slot[4];
   endproperty
   a_right_slot: assert property (p_right_slot)
      else $error("right half slot below 16");

   for (genvar gi = 0; gi < NCH; gi++) begin : g_chk
      property p_pin_route;
         @(posedge lclk) disable iff (!lrst_n)
         last && en_l[gi] && slot_l[gi] == cur_slot
         |=> hold[gi] == ($past(pin_l[gi]) ? $past(w2) : $past(w1));
      endproperty
      a_pin_route: assert property (p_pin_route)
         else $error("channel word taken from wrong pin");

      property p_disabled;
         @(posedge lclk) disable iff (!lrst_n)
         !en_l[gi] |=> $stable(tog[gi]);
      endproperty
      a_disabled: assert property (p_disabled)
         else $error("disabled channel delivered a word");
   end

   c_sample: cover property (@(posedge clock) disable iff (!arst_n)
                             |chan_valid);
   c_right: cover property (@(posedge lclk) disable iff (!lrst_n)
                            last && half);
   c_delay: cover property (@(posedge lclk) disable iff (!lrst_n)
                            first_bit && tgt_q == 6'h1F);

endmodule // sar_rx

// ==== verif/sar_host.sv ====
module sar_host;
   timeunit 1ns;
   timeprecision 1ps;

   // ****
   // Link pins driven by the host
   // ****
   logic bclk = 1'b0;
   logic fs   = 1'b0;
   logic sd1  = 1'b0;
   logic sd2  = 1'b0;

   // One bit period. The true values stand only around the capture edge
   // and the other edge sees their inverse, so a wrong edge shows.
   task automatic tick(input logic fe, input logic [2:0] v);
      {fs, sd1, sd2} = fe ? ~v : v;
      #31.25 bclk = 1'b1;
      #31.25 {fs, sd1, sd2} = fe ? v : ~v;
      #31.25 bclk = 1'b0;
      #31.25;
   endtask

   // A TDM frame; lead clocks let reset, config and clock switch settle.
   // With fe set the device captures on the falling bit clock edge.
   task automatic frame(input int d, input logic [127:0] a, b,
                        input logic fe);
      logic r1;
      logic r2;
      r1 = 1'b0;
      r2 = 1'b0;
      for (int i = -8; i < d + 132; i++) begin
         r1 = (i >= d && i < d + 128) ? a[127 - (i - d)] : ~r1;
         r2 = (i >= d && i < d + 128) ? b[127 - (i - d)] : ~r2;
         tick(fe, {i == 0, r1, r2});
      end
      // Released lines must not keep the last value.
      fs  = 1'b0;
      sd1 = ~sd1;
      sd2 = ~sd2;
   endtask
endmodule // sar_host

// ==== verif/tb_top.sv ====
module tb_top
   import sar_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;

   // ****
   // Signals
   // ****
   logic                 clock   = 1'b0;
   logic                 arst_n  = 1'b0;
   logic                 psel    = 1'b0;
   logic                 penable = 1'b0;
   logic                 pwrite  = 1'b0;
   logic                 fsel    = 1'b0;
   logic                 bsel    = 1'b0;
   logic [ADDR_W-1:0]    paddr   = '0;
   logic [31:0]          pwdata  = '0;
   logic [31:0]          prdata;
   logic                 pready;
   logic                 pslverr;
   logic [NCH-1:0][31:0] chan_data;
   logic [NCH-1:0]       chan_valid;
   logic [NCH-1:0][31:0] exp_data = '0;
   int                   err_total = 0;
   int                   total_checks = 0;
   int                   vcount = 0;
   int                   seed = 50164;

   // System clock, 200 MHz.
   always #2.5 clock = ~clock;

   sar_host host_u ();
   sar_rx dut_u (
      .clock(clock), .arst_n(arst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      // The unselected bit clock runs inverted, so a wrong pick shows.
      .bitclk_ext(host_u.bclk ^ bsel), .bitclk_int(host_u.bclk ^ ~bsel),
      .frame_sync_ext(~fsel & host_u.fs), .frame_sync_int(fsel & host_u.fs),
      .serial_in_first(host_u.sd1), .serial_in_second(host_u.sd2),
      .chan_data(chan_data), .chan_valid(chan_valid));

   // Counts delivery pulses so silent or doubled deliveries show.
   always @(posedge clock) vcount <= vcount + $countones(chan_valid);

   // ****
   // Tasks and functions
   // ****
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("[ERR] %0t ns: saw %h, expected %h", $time, seen, exp);
      end
   endtask

   // Request held until pready is sampled high at a rising edge.
   task automatic apb(input logic wr, input logic [7:0] idx,
                      input logic [31:0] wd, output logic [31:0] rd,
                      output logic err);
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= {idx, 2'b00};
      pwdata <= wd;
      @(posedge clock);
      penable <= 1'b1;
      @(posedge clock);
      while (pready !== 1'b1) @(posedge clock);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      // One idle cycle, so the next request never meets this release.
      @(posedge clock);
   endtask

   task automatic wr(input logic [7:0] idx, input logic [7:0] v);
      logic [31:0] rd;
      logic        err;
      apb(1'b1, idx, {24'h0, v}, rd, err);
      chk({31'h0, err}, 32'h0);
   endtask

   task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp,
                         input logic eerr);
      logic [31:0] rd;
      logic        err;
      apb(1'b0, idx, 32'h0, rd, err);
      chk(rd, exp);
      chk({31'h0, err}, {31'h0, eerr});
   endtask

   // Slot s of a frame, left aligned in a 32-bit word.
   function automatic logic [31:0] slot_word(input logic [127:0] v, int s);
      return {v[127 - 16 * s -: 16], 16'h0000};
   endfunction

   task automatic final_report();
      $display("checks %0d, mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // A hang ends the run as a failure.
   initial begin
      #400us;
      err_total++;
      final_report();
   end

   // ****
   // Main sequence
   // ****
   initial begin
      logic [127:0] a;
      logic [127:0] b;
      logic [7:0]   tim;
      logic [7:0]   sel;
      logic [7:0]   en;
      logic         mode;
      logic         pol;
      int           d;
      int           v0;
      // The link side leaves reset during the lead clocks of a frame.
      repeat (8) @(posedge clock);
      arst_n <= 1'b1;
      @(posedge clock);
      rd_chk(IDX_TIMING, 32'h0, 1'b0);
      rd_chk(IDX_PINSEL, 32'h0, 1'b0);
      rd_chk(8'h40, 32'h0, 1'b1);
      $display("register reset test done");
      // Random frames; first two hit delay corners 0 and 31.
      for (int f = 0; f < 12; f++) begin
         d   = (f == 0) ? 0 : (f == 1) ? 31 : $random(seed) & 31;
         tim = {3'($random(seed)), 5'(d)};
         sel = 8'($random(seed));
         en  = (f == 0) ? 8'hFF : 8'($random(seed));
         a   = {$random(seed), $random(seed), $random(seed), $random(seed)};
         b   = {$random(seed), $random(seed), $random(seed), $random(seed)};
         mode = 1'($random(seed));
         pol  = 1'($random(seed));
         wr(IDX_CTRL, {6'h00, pol, mode});
         wr(IDX_TIMING, tim);
         wr(IDX_PINSEL, sel);
         for (int n = 0; n < NCH; n++) wr(IDX_CHAN1 + 8'(n), {2'b0, en[n], 5'(n)});
         rd_chk(IDX_TIMING, {24'h0, tim}, 1'b0);
         rd_chk(IDX_PINSEL, {24'h0, sel}, 1'b0);
         // Internal sources count only in controller mode.
         fsel <= mode & tim[6];
         bsel <= mode & tim[5];
         v0 = vcount;
         // Capture falls on the falling edge when polarity and edge differ.
         host_u.frame(d, a, b, pol ^ tim[7]);
         repeat (20) @(posedge clock);
         for (int n = 0; n < NCH; n++) begin
            if (en[n]) exp_data[n] = slot_word(sel[n] ? b : a, n);
            chk(chan_data[n], exp_data[n]);
         end
         chk(32'(vcount - v0), 32'($countones(en)));
         $display("frame test %0d done", f);
      end
      final_report();
   end
endmodule // tb_top
